// [common/wg_pkg.sv]
// Constants and types shared by the setpoint waveform generator modules
package wg_pkg;
   localparam int VAL_W      = 16;
   localparam int TIME_W     = 32;
   localparam int FREQ_W     = 14;
   localparam int ACC_W      = 20;
   localparam int STEP_W     = 6;
   localparam int CLK_HZ     = 50_000_000;
   localparam int CLK_NS     = 20;
   // Phase time unit is 0.1 ms
   localparam int TICK_NS    = 100_000;
   localparam int TICK_CYC   = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int SINE_STEPS = 64;
   localparam logic [ACC_W-1:0]  STEP_MOD = ACC_W'(CLK_HZ / SINE_STEPS);
   localparam logic [FREQ_W-1:0] FREQ_MIN = 14'h0001;
   localparam logic [FREQ_W-1:0] FREQ_MAX = 14'h2710;
   localparam logic [TIME_W-1:0] TIME_MIN = 32'h0000_0001;
   localparam logic [TIME_W-1:0] TIME_MAX = 32'h1575_2a00;

   typedef enum logic [1:0] {
      WG_FN_SINE = 2'b00,
      WG_FN_TRI  = 2'b01,
      WG_FN_RECT = 2'b10
   } wg_func_e;

   typedef enum logic {
      TGT_VOLT = 1'b0,
      TGT_CURR = 1'b1
   } wg_tgt_e;

   typedef enum logic [1:0] {
      ST_OFF  = 2'b00,
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } wg_state_e;

   typedef struct packed {
      logic [TIME_W-1:0] div;
      logic [TIME_W-1:0] cnt;
      logic              tick;
      logic              done;
   } wg_tmr_s;

   typedef struct packed {
      wg_state_e                state;
      wg_func_e                 func;
      wg_tgt_e                  tgt;
      logic [VAL_W-1:0]         amp;
      logic signed [VAL_W:0]    offs;
      logic [FREQ_W-1:0]        freq;
      logic [TIME_W-1:0]        ph1_time;
      logic [TIME_W-1:0]        ph2_time;
      logic [VAL_W-1:0]         lim_volt;
      logic [VAL_W-1:0]         lim_curr;
      logic [VAL_W-1:0]         lim_pow;
      logic [VAL_W-1:0]         sink_cur;
      logic [VAL_W-1:0]         def_volt;
      logic [VAL_W-1:0]         def_curr;
      logic                     cfg_ok;
      logic                     phase;
      logic [ACC_W-1:0]         acc;
      logic [STEP_W-1:0]        step;
      logic                     out_on;
      logic                     running;
      logic                     alarm_rep;
      logic                     cfg_err;
      logic [VAL_W-1:0]         set_volt;
      logic signed [VAL_W:0]    set_curr;
      logic [VAL_W-1:0]         set_pow;
      logic [VAL_W-1:0]         set_sink;
      logic                     sink_en;
   } wg_main_s;

   localparam wg_tmr_s  RST_TMR  = '0;
   localparam wg_main_s RST_MAIN = '0;
endpackage : wg_pkg

// [common/wg_tmr_if.sv]
// Interface between the sequencer and the phase timer
`timescale 1ns/10ps
interface wg_tmr_if;
   import wg_pkg::*;
   logic              run;
   logic [TIME_W-1:0] limit;
   logic              tick;
   logic              done;
   logic [TIME_W-1:0] cnt;
   modport ctl (output run, output limit, input tick, input done, input cnt);
   modport tmr (input run, input limit, output tick, output done, output cnt);
endinterface : wg_tmr_if

// [rtl/wg_phase_timer.sv]
// Phase timer: 0.1 ms tick divider and phase length counter
`timescale 1ns/10ps
module wg_phase_timer
   import wg_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYC
) (
   input  logic      clk,
   input  logic      srst,
   wg_tmr_if.tmr     tif
);
   localparam logic [TIME_W-1:0] DIV_LAST = TIME_W'(TICK_LEN - 1);

   wg_tmr_s q_r;
   wg_tmr_s q_nxt;

   always_comb begin
      q_nxt      = q_r;
      q_nxt.tick = 1'b0;
      q_nxt.done = 1'b0;
      if (!tif.run) begin
         q_nxt.div = '0;
         q_nxt.cnt = '0;
      end else if (q_r.div == DIV_LAST) begin
         q_nxt.div  = '0;
         q_nxt.tick = 1'b1;
         // [RULE22] tick count ends phase
         if (q_r.cnt + 32'h0000_0001 >= tif.limit) begin
            q_nxt.cnt  = '0;
            q_nxt.done = 1'b1;
         end else begin
            q_nxt.cnt = q_r.cnt + 32'h0000_0001;
         end
      end else begin
         q_nxt.div = q_r.div + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q_r <= RST_TMR;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign tif.tick = q_r.tick;
   assign tif.done = q_r.done;
   assign tif.cnt  = q_r.cnt;
endmodule : wg_phase_timer

// [rtl/wg_setpoint_gen.sv]
// Setpoint waveform generator: sequencer, wave shapes and set-value outputs
//
// Contract
// [RULE1] Configuration accepted only with output off and resistance mode off.
// [RULE2] Wave modulates either voltage or current set value, chosen per function.
// [RULE3] Voltage, current and power limits are held for the run.
// [RULE4] The two unmodulated set values stay constant and clamp as usual.
// [RULE5] Default set values apply while output is on but no wave runs.
// [RULE6] No source/sink selection; direction follows the set values alone.
// [RULE7] Operator zeroes opposite-direction current and power to stay one-way.
// [RULE8] Voltage wave sinks only if terminal exceeds peak and sink current nonzero.
// [RULE9] Start command or on/off button while off starts the wave.
// [RULE10] Stop command halts the wave, output stays on with global values.
// [RULE11] On/off button during a run halts the wave and switches off.
// [RULE12] Alarm or protection trip aborts, switches off, reports the alarm.
// [RULE13] Global and some wave values change during a run without stopping.
// [RULE14] Sine frequency programmable from 1 to 10,000 Hz.
// [RULE15] Sine is offset plus amplitude times sine; bad offsets rejected.
// [RULE16] Current sine offset may go negative; source/sink follows its sign.
// [RULE17] Triangle rises over first time, falls over second time.
// [RULE18] Triangle period is the sum of both phase times.
// [RULE19] Rectangle holds top level for first time, offset for second.
// [RULE20] Triangle/rectangle amplitude up to nominal, offset to nominal minus amplitude.
// [RULE21] Rectangle period is pulse plus pause; duty is pulse over period.
// [RULE22] Phase times count in 0.1 ms ticks; phase ends at programmed count.
`timescale 1ns/10ps
module wg_setpoint_gen
   import wg_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYC
) (
   input  logic                  clk,
   input  logic                  srst,
   input  logic                  cfg_wr,
   input  logic [1:0]            cfg_func,
   input  logic                  cfg_tgt,
   input  logic [VAL_W-1:0]      cfg_amp,
   input  logic signed [VAL_W:0] cfg_offs,
   input  logic [FREQ_W-1:0]     cfg_freq,
   input  logic [TIME_W-1:0]     first_phase_time,
   input  logic [TIME_W-1:0]     second_phase_time,
   input  logic                  lim_wr,
   input  logic [VAL_W-1:0]      lim_volt,
   input  logic [VAL_W-1:0]      lim_curr,
   input  logic [VAL_W-1:0]      lim_pow,
   input  logic [VAL_W-1:0]      sink_current_setpoint,
   input  logic [VAL_W-1:0]      def_volt,
   input  logic [VAL_W-1:0]      def_curr,
   input  logic [VAL_W-1:0]      nom_volt,
   input  logic [VAL_W-1:0]      nom_curr,
   input  logic                  res_mode,
   input  logic [VAL_W-1:0]      term_volt,
   input  logic                  start_cmd,
   input  logic                  stop_cmd,
   input  logic                  onoff_btn,
   input  logic                  sys_alarm,
   input  logic                  overpower_protection,
   input  logic                  overcurrent_protection,
   input  logic                  evt_alarm,
   input  logic                  alarm_clr,
   output logic                  out_on,
   output logic                  running,
   output logic                  alarm_rep,
   output logic                  cfg_err,
   output logic                  cfg_ok,
   output logic [VAL_W-1:0]      set_volt,
   output logic signed [VAL_W:0] set_curr,
   output logic [VAL_W-1:0]      set_pow,
   output logic [VAL_W-1:0]      set_sink_curr,
   output logic                  sink_en
);

   // Range check shared by full load and live update
   function automatic logic cfg_valid(
      input wg_func_e              func,
      input wg_tgt_e               tgt,
      input logic [VAL_W-1:0]      amp,
      input logic signed [VAL_W:0] offs,
      input logic [FREQ_W-1:0]     freq,
      input logic [TIME_W-1:0]     ta,
      input logic [TIME_W-1:0]     tb,
      input logic [VAL_W-1:0]      nom
   );
      logic signed [VAL_W+1:0] a_s;
      logic signed [VAL_W+1:0] o_s;
      logic signed [VAL_W+1:0] n_s;
      logic                    ok;
      a_s = $signed({2'b00, amp});
      o_s = $signed({offs[VAL_W], offs});
      n_s = $signed({2'b00, nom});
      ok  = (a_s <= n_s) && (o_s + a_s <= n_s);
      if (func == WG_FN_SINE) begin
         // [RULE14] frequency range
         ok = ok && (freq >= FREQ_MIN) && (freq <= FREQ_MAX);
         if (tgt == TGT_VOLT) begin
            // [RULE15] offset not below amplitude
            ok = ok && (o_s >= a_s);
         end else begin
            // [RULE16] negative offset allowed
            ok = ok && (o_s - a_s >= -n_s);
         end
      end else if (func == WG_FN_TRI || func == WG_FN_RECT) begin
         // [RULE20] foot-based offset range
         ok = ok && (o_s >= $signed(18'h00000));
         ok = ok && (ta >= TIME_MIN) && (ta <= TIME_MAX);
         ok = ok && (tb >= TIME_MIN) && (tb <= TIME_MAX);
      end else begin
         ok = 1'b0;
      end
      return ok;
   endfunction : cfg_valid

   // Quarter-wave sine table, 17 points, full scale 255
   function automatic logic [7:0] sin_lut(input logic [4:0] k);
      logic [7:0] v;
      case (k)
         5'h00: v = 8'h00;
         5'h01: v = 8'h19;
         5'h02: v = 8'h32;
         5'h03: v = 8'h4a;
         5'h04: v = 8'h62;
         5'h05: v = 8'h79;
         5'h06: v = 8'h8e;
         5'h07: v = 8'ha2;
         5'h08: v = 8'hb4;
         5'h09: v = 8'hc5;
         5'h0a: v = 8'hd4;
         5'h0b: v = 8'he1;
         5'h0c: v = 8'hec;
         5'h0d: v = 8'hf4;
         5'h0e: v = 8'hfa;
         5'h0f: v = 8'hfe;
         default: v = 8'hff;
      endcase
      return v;
   endfunction : sin_lut

   wg_main_s q_r;
   wg_main_s q_nxt;

   wg_tmr_if tif ();

   wg_phase_timer #(
      .TICK_LEN (TICK_LEN)
   ) u_tmr (
      .clk  (clk),
      .srst (srst),
      .tif  (tif)
   );

   // Timer runs only for timed shapes
   assign tif.run   = (q_r.state == ST_RUN) && (q_r.func != WG_FN_SINE);
   assign tif.limit = q_r.phase ? q_r.ph2_time : q_r.ph1_time;

   always_comb begin
      logic                    alarm_in;
      logic                    go;
      logic                    ok;
      logic [VAL_W-1:0]        nom;
      logic [ACC_W:0]          acc_sum;
      logic [4:0]              sidx;
      logic [23:0]             sprod;
      logic signed [VAL_W+1:0] smag;
      logic signed [VAL_W+1:0] base;
      logic signed [VAL_W+1:0] amp_s;
      logic signed [VAL_W+1:0] ramp;
      logic signed [VAL_W+1:0] wave;
      logic signed [VAL_W+1:0] peak;
      logic [47:0]             tnum;
      logic [TIME_W-1:0]       tden;
      logic [47:0]             tquo;
      alarm_in = 1'b0;
      go       = 1'b0;
      ok       = 1'b0;
      nom      = '0;
      acc_sum  = '0;
      sidx     = '0;
      sprod    = '0;
      smag     = '0;
      base     = '0;
      amp_s    = '0;
      ramp     = '0;
      wave     = '0;
      peak     = '0;
      tnum     = '0;
      tden     = '0;
      tquo     = '0;
      q_nxt    = q_r;

      // Run control
      alarm_in = sys_alarm | overpower_protection | overcurrent_protection | evt_alarm;
      case (q_r.state)
         ST_OFF: begin
            // [RULE9] start also powers up
            if (onoff_btn || (start_cmd && q_r.cfg_ok)) begin
               q_nxt.state = q_r.cfg_ok ? ST_RUN : ST_IDLE;
               go          = q_r.cfg_ok;
            end
         end
         ST_IDLE: begin
            if (onoff_btn) begin
               q_nxt.state = ST_OFF;
            end else if (start_cmd && q_r.cfg_ok) begin
               // [RULE9] start from idle
               q_nxt.state = ST_RUN;
               go          = 1'b1;
            end
         end
         ST_RUN: begin
            if (onoff_btn) begin
               // [RULE11] halt and switch off
               q_nxt.state = ST_OFF;
            end else if (stop_cmd) begin
               // [RULE10] halt, output stays on
               q_nxt.state = ST_IDLE;
            end
         end
         default: begin
            q_nxt.state = ST_OFF;
         end
      endcase

      // Clear first so a coincident alarm stays reported
      if (alarm_clr) begin
         q_nxt.alarm_rep = 1'b0;
      end
      // [RULE12] abort and report
      if (alarm_in) begin
         q_nxt.state     = ST_OFF;
         q_nxt.alarm_rep = 1'b1;
         go              = 1'b0;
      end

      // Configuration writes
      if (cfg_wr) begin
         if (q_r.state == ST_OFF && !res_mode) begin
            // [RULE1] full load only while off
            nom = (cfg_tgt == TGT_CURR) ? nom_curr : nom_volt;
            ok  = cfg_valid(wg_func_e'(cfg_func), wg_tgt_e'(cfg_tgt), cfg_amp, cfg_offs,
                            cfg_freq, first_phase_time, second_phase_time, nom);
            if (ok) begin
               // [RULE2] target chosen per function
               q_nxt.func   = wg_func_e'(cfg_func);
               q_nxt.tgt    = wg_tgt_e'(cfg_tgt);
               q_nxt.cfg_ok = 1'b1;
            end
         end else if (q_r.state != ST_OFF) begin
            // [RULE13] live update keeps shape and target
            nom = (q_r.tgt == TGT_CURR) ? nom_curr : nom_volt;
            ok  = cfg_valid(q_r.func, q_r.tgt, cfg_amp, cfg_offs, cfg_freq,
                            first_phase_time, second_phase_time, nom);
         end
         if (ok) begin
            q_nxt.amp      = cfg_amp;
            q_nxt.offs     = cfg_offs;
            q_nxt.freq     = cfg_freq;
            q_nxt.ph1_time = first_phase_time;
            q_nxt.ph2_time = second_phase_time;
         end
         q_nxt.cfg_err = !ok;
      end

      // [RULE3] limits and defaults, accepted at any time
      if (lim_wr) begin
         q_nxt.lim_volt = lim_volt;
         q_nxt.lim_curr = lim_curr;
         q_nxt.lim_pow  = lim_pow;
         q_nxt.sink_cur = sink_current_setpoint;
         q_nxt.def_volt = def_volt;
         q_nxt.def_curr = def_curr;
      end

      // Phase and sine step progress
      if (go || q_r.state != ST_RUN) begin
         q_nxt.phase = 1'b0;
         q_nxt.acc   = '0;
         q_nxt.step  = '0;
      end else begin
         // [RULE17] phase flips at each phase end
         if (tif.done) begin
            q_nxt.phase = ~q_r.phase;
         end
         // [RULE14] exact rate: 64 steps per period
         acc_sum = {1'b0, q_r.acc} + {{(ACC_W+1-FREQ_W){1'b0}}, q_r.freq};
         if (acc_sum >= {1'b0, STEP_MOD}) begin
            q_nxt.acc  = ACC_W'(acc_sum - {1'b0, STEP_MOD});
            q_nxt.step = q_r.step + 6'h01;
         end else begin
            q_nxt.acc = acc_sum[ACC_W-1:0];
         end
      end

      // Wave value
      base  = $signed({q_r.offs[VAL_W], q_r.offs});
      amp_s = $signed({2'b00, q_r.amp});
      sidx  = q_r.step[4] ? (5'h10 - {1'b0, q_r.step[3:0]}) : {1'b0, q_r.step[3:0]};
      sprod = 24'(q_r.amp) * 24'(sin_lut(sidx));
      smag  = $signed({2'b00, sprod[23:8]});
      tden  = q_r.phase ? q_r.ph2_time : q_r.ph1_time;
      tnum  = 48'(q_r.amp) * 48'(tif.cnt);
      if (tden != '0) begin
         tquo = tnum / {16'h0000, tden};
      end
      ramp = $signed({2'b00, tquo[VAL_W-1:0]});
      case (q_r.func)
         WG_FN_SINE: begin
            // [RULE15] offset plus scaled sine
            wave = q_r.step[5] ? (base - smag) : (base + smag);
         end
         WG_FN_TRI: begin
            // [RULE18] rise then fall, period is the sum
            wave = q_r.phase ? (base + amp_s - ramp) : (base + ramp);
         end
         WG_FN_RECT: begin
            // [RULE19] pulse level then pause level
            // [RULE21] period is pulse plus pause
            wave = q_r.phase ? base : (base + amp_s);
         end
         default: begin
            wave = base;
         end
      endcase
      peak = base + amp_s;

      // Set-value outputs
      q_nxt.set_pow  = q_r.lim_pow;
      q_nxt.set_sink = q_r.sink_cur;
      if (q_r.state != ST_RUN) begin
         // [RULE5] defaults outside a run
         q_nxt.set_volt = q_r.def_volt;
         q_nxt.set_curr = $signed({1'b0, q_r.def_curr});
      end else if (q_r.tgt == TGT_VOLT) begin
         // [RULE2] voltage modulated only
         q_nxt.set_volt = (wave < 0) ? '0 : wave[VAL_W-1:0];
         // [RULE4] current held constant
         q_nxt.set_curr = $signed({1'b0, q_r.lim_curr});
      end else begin
         // [RULE4] voltage held constant
         q_nxt.set_volt = q_r.lim_volt;
         q_nxt.set_curr = wave[VAL_W:0];
      end

      // [RULE6] direction derived from values only
      if (q_r.state == ST_OFF) begin
         q_nxt.sink_en = 1'b0;
      end else if (q_r.state == ST_RUN && q_r.tgt == TGT_CURR) begin
         // [RULE16] sink while current is negative
         q_nxt.sink_en = (wave < 0);
      end else if (q_r.state == ST_RUN) begin
         // [RULE8] terminal above peak and sink current set
         // [RULE7] zero sink current keeps source only
         q_nxt.sink_en = ($signed({2'b00, term_volt}) > peak) && (q_r.sink_cur != '0);
      end else begin
         q_nxt.sink_en = (term_volt > q_r.def_volt) && (q_r.sink_cur != '0);
      end

      q_nxt.out_on  = (q_nxt.state != ST_OFF);
      q_nxt.running = (q_nxt.state == ST_RUN);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q_r <= RST_MAIN;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign out_on        = q_r.out_on;
   assign running       = q_r.running;
   assign alarm_rep     = q_r.alarm_rep;
   assign cfg_err       = q_r.cfg_err;
   assign cfg_ok        = q_r.cfg_ok;
   assign set_volt      = q_r.set_volt;
   assign set_curr      = q_r.set_curr;
   assign set_pow       = q_r.set_pow;
   assign set_sink_curr = q_r.set_sink;
   assign sink_en       = q_r.sink_en;
endmodule : wg_setpoint_gen

// [test/wg_chk.sv]
// Concurrent checks on the waveform generator ports
`timescale 1ns/10ps
module wg_chk
   import wg_pkg::*;
(
   input logic                  clk,
   input logic                  srst,
   input logic                  cfg_wr,
   input logic                  res_mode,
   input logic                  lim_wr,
   input logic [VAL_W-1:0]      lim_pow,
   input logic [VAL_W-1:0]      sink_current_setpoint,
   input logic [VAL_W-1:0]      def_volt,
   input logic [VAL_W-1:0]      def_curr,
   input logic [VAL_W-1:0]      term_volt,
   input logic                  start_cmd,
   input logic                  stop_cmd,
   input logic                  onoff_btn,
   input logic                  sys_alarm,
   input logic                  overpower_protection,
   input logic                  overcurrent_protection,
   input logic                  evt_alarm,
   input logic                  out_on,
   input logic                  running,
   input logic                  alarm_rep,
   input logic                  cfg_err,
   input logic                  cfg_ok,
   input logic [VAL_W-1:0]      set_volt,
   input logic signed [VAL_W:0] set_curr,
   input logic [VAL_W-1:0]      set_pow,
   input logic                  sink_en
);
   logic [VAL_W-1:0] dv_r, dc_r, lp_r, sk_r;
   logic             trip;
   assign trip = sys_alarm | overpower_protection | overcurrent_protection | evt_alarm;
   // Shadow of the stored limit set
   always_ff @(posedge clk) begin
      if (srst) begin
         {dv_r, dc_r, lp_r, sk_r} <= '0;
      end else if (lim_wr) begin
         {dv_r, dc_r, lp_r, sk_r} <= {def_volt, def_curr, lim_pow, sink_current_setpoint};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_cfg_locked: assert property (cfg_wr && !out_on && res_mode |=> cfg_err)
      else $error("config accepted while locked");
   a_alarm_abort: assert property (trip |=> !out_on && !running && alarm_rep)
      else $error("alarm did not abort the run");
   a_stop_hold: assert property (
      stop_cmd && running && !trip && !onoff_btn |=> out_on && !running)
      else $error("stop did not keep output on");
   a_onoff_halt: assert property (
      onoff_btn && running && !trip |=> !out_on && !running)
      else $error("on/off did not halt and switch off");
   a_start_run: assert property (
      ((start_cmd && !onoff_btn && !running) || (onoff_btn && !out_on))
      && cfg_ok && !trip |=> running && out_on)
      else $error("run did not start");
   a_start_refuse: assert property (
      start_cmd && !cfg_ok && !out_on && !onoff_btn |=> !running)
      else $error("run started without configuration");
   a_idle_dflt: assert property (out_on && !running
      |=> set_volt == $past(dv_r) && set_curr == $signed({1'b0, $past(dc_r)}))
      else $error("defaults not applied while idle");
   a_pow_hold: assert property (out_on |=> set_pow == $past(lp_r))
      else $error("power limit not held");
   a_idle_sink: assert property (out_on && !running
      |=> sink_en == ($past(term_volt) > $past(dv_r) && $past(sk_r) != '0))
      else $error("idle sink enable wrong");
   a_off_quiet: assert property (!out_on |=> !sink_en)
      else $error("sink enabled while off");
endmodule : wg_chk

bind wg_setpoint_gen wg_chk chk_u (.*);

// [test/wg_stage_model.sv]
// Power stage stand-in: terminal voltage and overcurrent trip
`timescale 1ns/10ps
module wg_stage_model
   import wg_pkg::*;
(
   input  logic                  clk,
   input  logic                  out_on,
   input  logic signed [VAL_W:0] set_curr,
   input  logic [VAL_W-1:0]      ext_volt,
   input  logic [VAL_W-1:0]      trip_lvl,
   output logic [VAL_W-1:0]      term_volt,
   output logic                  overcurrent_protection
);
   assign term_volt = ext_volt;
   initial overcurrent_protection = 1'b0;
   always @(posedge clk) begin
      overcurrent_protection <= out_on && (set_curr > $signed({1'b0, trip_lvl}));
   end
endmodule : wg_stage_model

// [test/wg_setpoint_gen_bench.sv]
// Self-checking bench for the setpoint waveform generator
`timescale 1ns/10ps
module wg_setpoint_gen_bench;
   import wg_pkg::*;
   logic clk, srst, cfg_wr, cfg_tgt, lim_wr, res_mode, start_cmd, stop_cmd, onoff_btn;
   logic sys_alarm, overpower_protection, overcurrent_protection, evt_alarm, alarm_clr;
   logic out_on, running, alarm_rep, cfg_err, cfg_ok, sink_en;
   logic [1:0]            cfg_func;
   logic [VAL_W-1:0]      cfg_amp, lim_volt, lim_curr, lim_pow, sink_current_setpoint;
   logic [VAL_W-1:0]      def_volt, def_curr, nom_volt, nom_curr, term_volt, ext_volt;
   logic [VAL_W-1:0]      trip_lvl, set_volt, set_pow, set_sink_curr;
   logic signed [VAL_W:0] cfg_offs, set_curr;
   logic [VAL_W:0]        a, b;
   logic [FREQ_W-1:0]     cfg_freq;
   logic [TIME_W-1:0]     first_phase_time, second_phase_time;
   int                    n_mismatch, cmp_count, i;

   wg_setpoint_gen #(.TICK_LEN(4)) dut_u (.*);

   wg_stage_model stage_u (
      .clk(clk), .out_on(out_on), .set_curr(set_curr), .ext_volt(ext_volt),
      .trip_lvl(trip_lvl), .term_volt(term_volt),
      .overcurrent_protection(overcurrent_protection));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   // One-cycle strobe, ends at the next falling edge
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse

   task automatic cfg(input logic [1:0] f, input logic t, input int am, input int of,
                      input int fr, input int pa, input int pb);
      {cfg_func, cfg_tgt, cfg_amp, cfg_offs} = {f, t, 16'(am), 17'(of)};
      {cfg_freq, first_phase_time, second_phase_time} = {14'(fr), 32'(pa), 32'(pb)};
      // Gap keeps back-to-back strobes apart
      cyc(1);
      pulse(cfg_wr);
   endtask : cfg

   task automatic lim(input int sk);
      {lim_volt, lim_curr, lim_pow} = {16'h01f4, 16'h00c8, 16'h0384};
      {sink_current_setpoint, def_volt, def_curr} = {16'(sk), 16'h0028, 16'h001e};
      pulse(lim_wr);
   endtask : lim

   initial begin
      {cfg_wr, cfg_tgt, lim_wr, res_mode, start_cmd, stop_cmd, onoff_btn, sys_alarm} = '0;
      {overpower_protection, evt_alarm, alarm_clr, cfg_func, cfg_amp, cfg_offs} = '0;
      {cfg_freq, first_phase_time, second_phase_time, lim_volt, lim_curr, lim_pow} = '0;
      {sink_current_setpoint, def_volt, def_curr, ext_volt} = '0;
      {nom_volt, nom_curr, trip_lvl, srst} = {16'h03e8, 16'h03e8, 16'h7fff, 1'b1};
      cyc(3);
      srst = 1'b0;
      cyc(1);
      pulse(start_cmd);
      chk(running, 0);
      res_mode = 1'b1;
      cfg(2'b10, 0, 100, 50, 1, 3, 2);
      chk(cfg_err, 1);
      res_mode = 1'b0;
      cfg(2'b00, 0, 100, 200, 10001, 1, 1);
      chk(cfg_err, 1);
      cfg(2'b00, 0, 100, 50, 100, 1, 1);
      chk(cfg_err, 1);
      cfg(2'b01, 1, 100, -1, 1, 3, 2);
      chk(cfg_err, 1);
      cfg(2'b10, 0, 100, 950, 1, 3, 2);
      chk(cfg_err, 1);
      cfg(2'b10, 0, 100, 0, 1, 0, 2);
      chk(cfg_err, 1);
      cfg(2'b11, 0, 100, 50, 1, 3, 2);
      chk(cfg_ok, 0);
      cfg(2'b10, 0, 100, 50, 1, 3, 2);
      chk(cfg_ok, 1);
      lim(0);
      pulse(onoff_btn);
      chk({out_on, running}, 2'b11);
      cyc(6);
      chk(set_volt, 150);
      chk(set_curr, 200);
      chk(set_pow, 900);
      cyc(10);
      chk(set_volt, 50);
      cyc(8);
      chk(set_volt, 150);
      cfg(2'b10, 0, 200, 50, 1, 3, 2);
      chk({running, cfg_err}, 2'b10);
      for (i = 0; i < 30 && set_volt !== 16'h00fa; i++) cyc(1);
      chk(set_volt, 250);
      if (n_mismatch != 0) results();
      pulse(stop_cmd);
      chk({out_on, running}, 2'b10);
      cyc(1);
      chk(set_volt, 40);
      chk(set_curr, 30);
      ext_volt = 16'h003c;
      cyc(2);
      chk(sink_en, 0);
      lim(10);
      cyc(2);
      chk(sink_en, 1);
      chk(set_sink_curr, 10);
      ext_volt = 16'h012c;
      pulse(start_cmd);
      chk(running, 1);
      pulse(onoff_btn);
      chk({out_on, running}, 2'b00);
      chk(sink_en, 1);
      cfg(2'b01, 1, 80, 20, 1, 4, 4);
      chk(cfg_err, 0);
      pulse(onoff_btn);
      cyc(3);
      a = set_curr;
      cyc(8);
      b = set_curr;
      chk(b > a, 1);
      chk(set_volt, 500);
      trip_lvl = 16'h003c;
      for (i = 0; i < 40 && out_on !== 1'b0; i++) cyc(1);
      chk({out_on, alarm_rep}, 2'b01);
      if (n_mismatch != 0) results();
      trip_lvl = 16'h7fff;
      cyc(2);
      for (int k = 0; k < 3; k++) begin
         pulse(alarm_clr);
         chk(alarm_rep, 0);
         pulse(onoff_btn);
         chk(running, 1);
         case (k)
            0: pulse(sys_alarm);
            1: pulse(overpower_protection);
            default: pulse(evt_alarm);
         endcase
         chk({out_on, running, alarm_rep}, 3'b001);
      end
      pulse(alarm_clr);
      cfg(2'b00, 1, 100, -50, 10000, 1, 1);
      chk(cfg_err, 0);
      pulse(onoff_btn);
      for (i = 0; i < 6000 && sink_en !== 1'b1; i++) cyc(1);
      chk(sink_en, 1);
      results();
   end
endmodule : wg_setpoint_gen_bench
